/* File: hw/clock_gen_and_timewheels.sv */
`timescale 1ns/10ps
module clock_gen_and_timewheels
    import clkgen_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_b_i,
    input  wire logic [7:0]              addr_i,
    input  wire logic [31:0]             wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [31:0]             rdata_o,
    input  wire logic                    slow_tick_clock_i,
    input  wire logic                    fast_tick_clock_i,
    input  wire logic                    main_internal_oscillator_i,
    input  wire logic                    fast_crystal_oscillator_i,
    input  wire logic                    watch_crystal_oscillator_i,
    input  wire logic                    dsi_clk_i,
    input  wire logic                    hibernate_i,
    input  wire logic                    debug_halt_i,
    output logic                         ctw_wake_o,
    output logic                         ctw_irq_o,
    output logic                         ftw_irq_o,
    output logic                         reduced_accuracy_watch_clock_o,
    output logic                         pll_lock_o,
    output logic                         pll_ref_en_o,
    output logic                         pll_run_o,
    output logic [1:0]                   pll_ref_sel_o,
    output logic [11:0]                  pll_ratio_o,
    output logic [2:0]                   imo_freq_o,
    output logic                         dbl_en_o,
    output logic [1:0]                   dbl_src_o,
    output logic                         bus_clk_en_o,
    output logic                         cpu_clk_en_o,
    output logic [NUM_DIVIDERS-1:0]      div_clk_o
);

    // edge detect on the sampled oscillator ticks (inputs are synchronous)
    logic slow_d_r;
    logic fast_d_r;
    wire  slow_tick = slow_tick_clock_i & ~slow_d_r;
    wire  fast_tick = fast_tick_clock_i & ~fast_d_r;

    reg_req_t req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    logic [15:0] ctrl_r;
    logic [12:0] ctw_cnt_r;
    logic [12:0] ctw_wake_r;
    logic [4:0]  ftw_term_r;
    logic [4:0]  ftw_cnt_r;
    logic [13:0] pll_cfg_r;
    logic [15:0] bus_div_r;
    logic [15:0] bus_cnt_r;
    logic [1:0]  div3_cnt_r;
    logic [15:0] lock_cnt_r;
    pll_state_t  pll_st_r;
    div_cfg_t    div_cfg_r [NUM_DIVIDERS];
    logic [15:0] div_cnt_r [NUM_DIVIDERS];
    logic [NUM_DIVIDERS-1:0] div_src_d_r;
    logic [NUM_DIVIDERS-1:0] div_out_r;

    wire wr_ctrl  = req.wr && (req.addr == REG_CTRL);
    wire wr_ctw   = req.wr && (req.addr == REG_CTW_WAKE);
    wire wr_ftw   = req.wr && (req.addr == REG_FTW_TERM);
    wire wr_pll   = req.wr && (req.addr == REG_PLL_CFG);
    wire wr_bus   = req.wr && (req.addr == REG_BUS_DIV);
    wire ctw_clr  = wr_ctrl && req.wdata[CTRL_CTW_RST];
    wire ctw_run  = slow_tick && !hibernate_i && !debug_halt_i;
    wire ctw_hit  = ctw_run && (ctw_cnt_r == ctw_wake_r);
    wire ftw_hit  = fast_tick && (ftw_cnt_r == ftw_term_r);

    // ratio below two is clamped to two so dividers never pass the source
    function automatic logic [15:0] half_ratio(input logic [15:0] r);
        logic [15:0] rr;
        rr = (r < 16'h0002) ? 16'h0002 : r;
        return {1'b0, rr[15:1]};
    endfunction : half_ratio

    // eight sources: oscillators plus chained outputs of divider 0/1
    function automatic logic pick_src(input logic [2:0] s, input logic [NUM_DIVIDERS-1:0] d);
        logic v;
        v = 1'b0;
        unique case (s)
            3'h0: v = main_internal_oscillator_i;
            3'h1: v = fast_crystal_oscillator_i;
            3'h2: v = dsi_clk_i;
            3'h3: v = fast_tick_clock_i;
            3'h4: v = slow_tick_clock_i;
            3'h5: v = watch_crystal_oscillator_i;
            3'h6: v = d[0];
            3'h7: v = d[1];
        endcase
        return v;
    endfunction : pick_src

    // register index of a divider: digital bank first, then analog bank
    function automatic logic [7:0] div_addr(input int i);
        return (i < DIG_DIVIDERS) ? REG_DIG_BASE + 8'(i)
                                  : REG_ANA_BASE + 8'(i - DIG_DIVIDERS);
    endfunction : div_addr

    // the unused fourth select code falls back to the main oscillator
    function automatic logic [1:0] fold_sel(input logic [1:0] s);
        return (s == 2'h3) ? REF_MAIN_OSC : s;
    endfunction : fold_sel

    // sampled oscillator levels for the tick edge detectors
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            slow_d_r <= 1'b0;
            fast_d_r <= 1'b0;
        end else begin
            slow_d_r <= slow_tick_clock_i;
            fast_d_r <= fast_tick_clock_i;
        end
    end

    // software configuration; the clear bit never stays set
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ctrl_r     <= CTRL_RESET;
            ctw_wake_r <= CTW_WAKE_RESET;
            ftw_term_r <= FTW_TERM_RESET;
            pll_cfg_r  <= 14'h0000;
            bus_div_r  <= DIV_RESET;
        end else begin
            if (wr_ctrl) ctrl_r <= {req.wdata[15:1], 1'b0};
            if (wr_ctw) ctw_wake_r <= req.wdata[12:0];
            if (wr_ftw) ftw_term_r <= req.wdata[4:0];
            if (wr_pll) pll_cfg_r <= req.wdata[13:0];
            if (wr_bus) bus_div_r <= req.wdata[15:0];
        end
    end

    // coarse counter: a clear beats a tick in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ctw_cnt_r <= 13'h0000;
        end else if (ctw_clr) begin
            ctw_cnt_r <= 13'h0000;
        end else if (ctw_run) begin
            ctw_cnt_r <= ctw_cnt_r + 13'h0001;
        end
    end

    // fast counter reloads itself at the terminal count
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ftw_cnt_r <= 5'h00;
        end else if (ftw_hit) begin
            ftw_cnt_r <= 5'h00;
        end else if (fast_tick) begin
            ftw_cnt_r <= ftw_cnt_r + 5'h01;
        end
    end

    // divide-by-three of fast tick clock; high for 1.5 ticks via both edges
    logic div3_hi_r;
    logic div3_lo_r;
    wire  fast_fall = ~fast_tick_clock_i & fast_d_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            div3_cnt_r <= 2'h0;
            div3_hi_r  <= 1'b0;
            div3_lo_r  <= 1'b0;
        end else begin
            if (fast_tick) div3_cnt_r <= (div3_cnt_r == 2'h2) ? 2'h0 : div3_cnt_r + 2'h1;
            if (fast_tick) div3_hi_r <= (div3_cnt_r == 2'h0);
            if (fast_fall) div3_lo_r <= div3_hi_r;
        end
    end

    // pll lock timer
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pll_st_r   <= PLL_OFF;
            lock_cnt_r <= 16'h0000;
        end else begin
            unique case (pll_st_r)
                PLL_OFF: begin
                    lock_cnt_r <= 16'h0000;
                    if (ctrl_r[CTRL_PLL_EN]) pll_st_r <= PLL_WAIT;
                end
                PLL_WAIT: begin
                    lock_cnt_r <= lock_cnt_r + 16'h0001;
                    if (!ctrl_r[CTRL_PLL_EN]) pll_st_r <= PLL_OFF;
                    else if (lock_cnt_r == 16'(PLL_LOCK_CYCLES - 1))
                        pll_st_r <= PLL_LOCK;
                end
                PLL_LOCK: begin
                    if (!ctrl_r[CTRL_PLL_EN]) pll_st_r <= PLL_OFF;
                end
            endcase
        end
    end

    // bus clock enable from 16-bit divider
    wire bus_wrap = (bus_cnt_r >= bus_div_r - 16'h0001) || (bus_div_r == 16'h0000);
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) bus_cnt_r <= 16'h0000;
        else bus_cnt_r <= bus_wrap ? 16'h0000 : bus_cnt_r + 16'h0001;
    end

    // dividers: 0..7 digital, 8..11 analog
    logic [NUM_DIVIDERS-1:0] src_now;
    always_comb begin
        for (int i = 0; i < NUM_DIVIDERS; i++) begin
            src_now[i] = pick_src(div_cfg_r[i].src, div_out_r);
        end
    end

    for (genvar g = 0; g < NUM_DIVIDERS; g++) begin : g_div
        wire rise = src_now[g] & ~div_src_d_r[g];
        wire [7:0] my_addr = div_addr(g);
        wire [15:0] half = half_ratio(div_cfg_r[g].ratio);
        wire [15:0] skew = (g < DIG_DIVIDERS) ? 16'h0000 : 16'(div_cfg_r[g].skew);
        always_ff @(posedge clk_sys_i) begin
            if (!rst_b_i) begin
                div_cfg_r[g]   <= '{ratio: DIV_RESET, src: 3'h0, skew: 2'h0};
                div_cnt_r[g]   <= 16'h0000;
                div_src_d_r[g] <= 1'b0;
                div_out_r[g]   <= 1'b0;
            end else begin
                div_src_d_r[g] <= src_now[g];
                if (req.wr && req.addr == my_addr)
                    div_cfg_r[g] <= '{ratio: req.wdata[15:0], src: req.wdata[18:16],
                                      skew: req.wdata[21:20]};
                if (rise) begin
                    // toggling every half ratio gives even duty
                    if (div_cnt_r[g] >= half - 16'h0001 + skew) begin
                        div_cnt_r[g] <= skew;
                        div_out_r[g] <= ~div_out_r[g];
                    end else begin
                        div_cnt_r[g] <= div_cnt_r[g] + 16'h0001;
                    end
                end
            end
        end
    end

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (req.addr)
            REG_CTRL:     rd_mux = {16'h0000, ctrl_r};
            REG_STATUS:   rd_mux = {29'h0, pll_st_r == PLL_LOCK, ftw_irq_o, ctw_irq_o};
            REG_CTW_CNT:  rd_mux = {19'h0, ctw_cnt_r};
            REG_CTW_WAKE: rd_mux = {19'h0, ctw_wake_r};
            REG_FTW_TERM: rd_mux = {27'h0, ftw_term_r};
            REG_FTW_CNT:  rd_mux = {27'h0, ftw_cnt_r};
            REG_PLL_CFG:  rd_mux = {18'h0, pll_cfg_r};
            REG_BUS_DIV:  rd_mux = {16'h0000, bus_div_r};
            default: begin
                for (int i = 0; i < NUM_DIVIDERS; i++) begin
                    if (req.addr == div_addr(i))
                        rd_mux = {10'h0, div_cfg_r[i].skew, 1'b0, div_cfg_r[i].src,
                                  div_cfg_r[i].ratio};
                end
            end
        endcase
    end

    // clamped selections for the registered outputs
    wire [1:0]  ref_sel_nxt = fold_sel(pll_cfg_r[13:12]);
    // ratio index 0..4031 selects input and feedback dividers
    wire [11:0] ratio_nxt   = (pll_cfg_r[11:0] > 12'hfbf) ? 12'hfbf : pll_cfg_r[11:0];
    wire [2:0]  imo_nxt     = (ctrl_r[10:8] > IMO_74M) ? IMO_74M : ctrl_r[10:8];
    wire [1:0]  dbl_src_nxt = fold_sel(ctrl_r[13:12]);

    // read data follows each cycle of rd_i one cycle later and is zero otherwise
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= req.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // timewheel events and the divided watch clock
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ctw_wake_o                     <= 1'b0;
            ctw_irq_o                      <= 1'b0;
            ftw_irq_o                      <= 1'b0;
            reduced_accuracy_watch_clock_o <= 1'b0;
        end else begin
            ctw_wake_o <= ctw_hit && ctrl_r[CTRL_CTW_WEN];
            ctw_irq_o  <= ctw_hit && ctrl_r[CTRL_CTW_WEN] && ctrl_r[CTRL_CTW_IEN];
            ftw_irq_o  <= ftw_hit && ctrl_r[CTRL_FTW_IEN];
            reduced_accuracy_watch_clock_o <= div3_hi_r | div3_lo_r;
        end
    end

    // pll status and control
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pll_lock_o    <= 1'b0;
            pll_ref_en_o  <= 1'b0;
            pll_run_o     <= 1'b0;
            pll_ref_sel_o <= 2'h0;
            pll_ratio_o   <= 12'h000;
        end else begin
            pll_lock_o    <= (pll_st_r == PLL_LOCK);
            pll_ref_en_o  <= 1'b1;
            pll_run_o     <= ctrl_r[CTRL_PLL_EN];
            pll_ref_sel_o <= ref_sel_nxt;
            pll_ratio_o   <= ratio_nxt;
        end
    end

    // oscillator and doubler controls
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            imo_freq_o <= 3'h0;
            dbl_en_o   <= 1'b0;
            dbl_src_o  <= 2'h0;
        end else begin
            imo_freq_o <= imo_nxt;
            dbl_en_o   <= ctrl_r[CTRL_DBL_EN];
            dbl_src_o  <= dbl_src_nxt;
        end
    end

    // clock enables and divider outputs
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            bus_clk_en_o <= 1'b0;
            cpu_clk_en_o <= 1'b0;
            div_clk_o    <= '0;
        end else begin
            bus_clk_en_o <= bus_wrap;
            cpu_clk_en_o <= bus_wrap;
            div_clk_o    <= div_out_r;
        end
    end

endmodule : clock_gen_and_timewheels

/* File: hw/clkgen_pkg.sv */
package clkgen_pkg;

    // register indices (byte address = index * 4 not used; plain port addressing)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h01;
    localparam logic [7:0] REG_CTW_CNT   = 8'h02;
    localparam logic [7:0] REG_CTW_WAKE  = 8'h03;
    localparam logic [7:0] REG_FTW_TERM  = 8'h04;
    localparam logic [7:0] REG_FTW_CNT   = 8'h05;
    localparam logic [7:0] REG_PLL_CFG   = 8'h06;
    localparam logic [7:0] REG_BUS_DIV   = 8'h07;
    localparam logic [7:0] REG_DIG_BASE  = 8'h10;
    localparam logic [7:0] REG_ANA_BASE  = 8'h18;

    // ctrl bits
    localparam int CTRL_CTW_RST   = 0;
    localparam int CTRL_CTW_WEN   = 1;
    localparam int CTRL_CTW_IEN   = 2;
    localparam int CTRL_FTW_IEN   = 3;
    localparam int CTRL_PLL_EN    = 4;
    localparam int CTRL_DBL_EN    = 5;
    localparam int CTRL_IMO_SEL   = 8;  // 3 bits
    localparam int CTRL_DBL_SRC   = 12; // 2 bits

    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [12:0] CTW_WAKE_RESET = 13'h1fff;
    localparam logic [4:0]  FTW_TERM_RESET = 5'h1f;
    localparam logic [15:0] DIV_RESET      = 16'h0001;

    localparam int CLK_SYS_HZ     = 10_000_000;
    localparam int PLL_LOCK_US    = 250;
    localparam int PLL_LOCK_CYC   = (CLK_SYS_HZ / 1_000_000) * PLL_LOCK_US;
    localparam int CLK_SOURCES    = 8;
    localparam int DIG_DIVIDERS   = 8;
    localparam int ANA_DIVIDERS   = 4;
    localparam int NUM_DIVIDERS   = DIG_DIVIDERS + ANA_DIVIDERS;

    typedef enum logic [2:0] {
        IMO_3M  = 3'h0,
        IMO_6M  = 3'h1,
        IMO_12M = 3'h2,
        IMO_24M = 3'h3,
        IMO_48M = 3'h4,
        IMO_74M = 3'h5
    } imo_freq_t;

    typedef enum logic [1:0] {
        REF_MAIN_OSC = 2'h0,
        REF_FAST_XO  = 2'h1,
        REF_DSI      = 2'h2
    } ref_sel_t;

    typedef enum logic [2:0] {
        PLL_OFF  = 3'b001,
        PLL_WAIT = 3'b010,
        PLL_LOCK = 3'b100
    } pll_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] ratio;
        logic [2:0]  src;
        logic [1:0]  skew;
    } div_cfg_t;

endpackage : clkgen_pkg

/* File: tb/clock_gen_and_timewheels_chk.sv */
`timescale 1ns/10ps
module clock_gen_and_timewheels_chk
    import clkgen_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic        ctw_wake_o,
    input  wire logic        ctw_irq_o,
    input  wire logic        ftw_irq_o,
    input  wire logic        pll_lock_o,
    input  wire logic        pll_ref_en_o,
    input  wire logic        pll_run_o,
    input  wire logic [1:0]  pll_ref_sel_o,
    input  wire logic [11:0] pll_ratio_o,
    input  wire logic [2:0]  imo_freq_o,
    input  wire logic        bus_clk_en_o,
    input  wire logic        cpu_clk_en_o
);
    // cycles spent waiting for lock since the pll was enabled
    int wait_cnt_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || !pll_run_o) begin
            wait_cnt_r <= 0;
        end else if (!pll_lock_o) begin
            wait_cnt_r <= wait_cnt_r + 1;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    a_cpu_follows_bus: assert property (cpu_clk_en_o == bus_clk_en_o)
        else $error("cpu clock enable differs from bus clock enable");
    a_ref_sel_legal: assert property (pll_ref_sel_o != 2'h3)
        else $error("pll reference select out of range");
    a_ratio_in_range: assert property (pll_ratio_o <= 12'hfbf)
        else $error("pll ratio above last ratio");
    a_imo_code_legal: assert property (imo_freq_o <= 3'h5)
        else $error("oscillator frequency code out of range");
    a_lock_needs_run: assert property ($rose(pll_lock_o) |-> pll_run_o)
        else $error("lock raised while pll disabled");
    a_lock_not_early: assert property ($rose(pll_lock_o) |-> wait_cnt_r >= PLL_LOCK_CYCLES - 1)
        else $error("lock raised too early");
    a_lock_in_time: assert property (wait_cnt_r <= PLL_LOCK_CYCLES + 3)
        else $error("lock not reached in time");
    a_ref_en_on: assert property ($past(rst_b_i, 2) && $past(rst_b_i) |-> pll_ref_en_o)
        else $error("pll reference not usable");
    a_irq_with_wake: assert property (ctw_irq_o |-> ctw_wake_o)
        else $error("coarse interrupt without wakeup");
    a_ftw_irq_single: assert property (ftw_irq_o |=> !ftw_irq_o)
        else $error("fast interrupt longer than one cycle");
endmodule : clock_gen_and_timewheels_chk

bind clock_gen_and_timewheels clock_gen_and_timewheels_chk #(
    .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)
) u_chk (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ctw_wake_o(ctw_wake_o), .ctw_irq_o(ctw_irq_o),
    .ftw_irq_o(ftw_irq_o), .pll_lock_o(pll_lock_o), .pll_ref_en_o(pll_ref_en_o),
    .pll_run_o(pll_run_o), .pll_ref_sel_o(pll_ref_sel_o), .pll_ratio_o(pll_ratio_o),
    .imo_freq_o(imo_freq_o), .bus_clk_en_o(bus_clk_en_o), .cpu_clk_en_o(cpu_clk_en_o)
);

/* File: tb/test_clock_gen_and_timewheels.sv */
`timescale 1ns/10ps
module test_clock_gen_and_timewheels;
    import clkgen_pkg::*;
    localparam int LOCK = 20;
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        slow = 1'b0, fast = 1'b0, mosc = 1'b0, hib = 1'b0, halt = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d, a;
    logic        wake, irq, firq, watch, lock, ref_en, run, dbl_en, bus_en, cpu_en;
    logic        seen_wake = 1'b0, seen_irq = 1'b0;
    logic [1:0]  ref_sel, dbl_src;
    logic [11:0] ratio, div;
    logic [2:0]  main_internal_oscillator;
    logic [14:0] probe;
    int          failures = 0, n_compared = 0, cyc = 0, i, r, h;
    logic [7:0]  rst_addr [5] = '{8'h00, 8'h03, 8'h04, 8'h07, 8'h08};
    logic [31:0] rst_val [5] = '{32'h0, 32'h1fff, 32'h1f, 32'h1, 32'h0};

    assign probe = {firq, bus_en, watch, div};
    always #50 clk = ~clk;
    // compressed tick rates: slow tick 4 cycles, fast tick 10 cycles
    always @(posedge clk) begin
        cyc  <= cyc + 1;
        mosc <= ~mosc;
        slow <= cyc[1];
        fast <= (cyc % 10) < 5;
        if (wake === 1'b1) begin
            seen_wake <= 1'b1;
        end
        if (irq === 1'b1) begin
            seen_irq <= 1'b1;
        end
    end

    clock_gen_and_timewheels #(.PLL_LOCK_CYCLES(LOCK)) DUT (
        .clk_sys_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .slow_tick_clock_i(slow), .fast_tick_clock_i(fast),
        .main_internal_oscillator_i(mosc), .fast_crystal_oscillator_i(1'b0),
        .watch_crystal_oscillator_i(1'b0), .dsi_clk_i(1'b0), .hibernate_i(hib),
        .debug_halt_i(halt), .ctw_wake_o(wake), .ctw_irq_o(irq), .ftw_irq_o(firq),
        .reduced_accuracy_watch_clock_o(watch), .pll_lock_o(lock), .pll_ref_en_o(ref_en),
        .pll_run_o(run), .pll_ref_sel_o(ref_sel), .pll_ratio_o(ratio), .imo_freq_o(main_internal_oscillator),
        .dbl_en_o(dbl_en), .dbl_src_o(dbl_src), .bus_clk_en_o(bus_en), .cpu_clk_en_o(cpu_en),
        .div_clk_o(div)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] ad, input logic [31:0] w);
        @(posedge clk);
        addr  <= ad;
        wdata <= w;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] ad, output logic [31:0] q);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 q = rdata;
    endtask : reg_rd

    // rising edges and high samples of one probe bit over n cycles
    task automatic measure(input int b, input int n, output int rises, output int highs);
        logic prev;
        rises = 0;
        highs = 0;
        repeat (16) @(posedge clk);
        #1 prev = probe[b];
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            #1 rises += int'(probe[b] && !prev);
            highs += int'(probe[b]);
            prev = probe[b];
        end
    endtask : measure

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    initial begin
        #(100 * 20000);
        failures++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 5; i++) begin
            reg_rd(rst_addr[i], d);
            check("reset value", d, rst_val[i]);
        end
        reg_wr(8'h10, 32'h0000_0004);
        reg_wr(8'h11, 32'h0006_0002);
        reg_wr(8'h18, 32'h0010_0002);
        measure(0, 80, r, h);
        check("div0 rises", r, 10);
        check("div0 high", h, 40);
        measure(1, 80, r, h);
        check("div1 chained rises", r, 5);
        measure(8, 80, r, h);
        check("analog div rises", r, 20);
        measure(2, 80, r, h);
        check("div2 default rises", r, 20);
        reg_wr(REG_BUS_DIV, 32'h4);
        measure(13, 80, r, h);
        check("bus enable pulses", r, 20);
        measure(12, 300, r, h);
        check("watch clock rises", r, 10);
        check("watch clock high", h, 150);
        hib <= 1'b1;
        reg_wr(REG_CTRL, 32'h1);
        repeat (20) @(posedge clk);
        reg_rd(REG_CTW_CNT, d);
        check("coarse after clear", d, 32'h0);
        hib <= 1'b0;
        reg_rd(REG_CTW_CNT, a);
        repeat (38) @(posedge clk);
        reg_rd(REG_CTW_CNT, d);
        check("coarse advance", d - a, 32'd10);
        halt <= 1'b1;
        repeat (8) @(posedge clk);
        reg_rd(REG_CTW_CNT, a);
        repeat (38) @(posedge clk);
        reg_rd(REG_CTW_CNT, d);
        check("coarse halted", d, a);
        halt <= 1'b0;
        reg_wr(REG_CTW_WAKE, 32'h3);
        reg_wr(REG_CTRL, 32'h7);
        repeat (40) @(posedge clk);
        check("coarse wake seen", seen_wake, 32'h1);
        check("coarse irq seen", seen_irq, 32'h1);
        reg_wr(REG_FTW_TERM, 32'h4);
        reg_wr(REG_CTRL, 32'h8);
        measure(14, 500, r, h);
        check("fast irq pulses", r, 10);
        for (i = 0; i < 4; i++) begin
            reg_wr(REG_PLL_CFG, (i << 12) | (i == 3 ? 32'hfff : 32'h64));
            repeat (2) @(posedge clk);
            #1 check("pll ref select", ref_sel, i == 3 ? 0 : i);
            check("pll ratio", ratio, i == 3 ? 32'hfbf : 32'h64);
        end
        reg_wr(REG_CTRL, 32'h10);
        #1 check("lock early", lock, 32'h0);
        check("reference usable", ref_en, 32'h1);
        for (i = 0; i < LOCK + 10 && lock !== 1'b1; i++) begin
            @(posedge clk);
        end
        #1 check("pll locked", lock, 32'h1);
        reg_rd(REG_STATUS, d);
        check("status lock", d[2], 32'h1);
        for (i = 0; i < 8; i++) begin
            reg_wr(REG_CTRL, 32'h30 | (i << 8) | ((i % 3) << 12));
            repeat (2) @(posedge clk);
            #1 check("imo code", main_internal_oscillator, i > 5 ? 5 : i);
            check("doubler enable", dbl_en, 32'h1);
            check("doubler source", dbl_src, i % 3);
        end
        final_report();
    end
endmodule : test_clock_gen_and_timewheels
